// >>> hw/seq_pin_defines.svh
// Offsets, field positions, reset values and codes of the control registers
`ifndef SEQ_PIN_DEFINES_SVH
`define SEQ_PIN_DEFINES_SVH
`define ADDR_MAIN       7'h00
`define ADDR_IFACE      7'h01
`define MAIN_POR        8'h00
`define IFACE_DEF       8'h00
`define M_DIR           7
`define M_BANK          6
`define M_PD_HI         5
`define M_PD_LO         4
`define M_CAL_HI        3
`define M_CAL_LO        2
`define M_SLEEP         1
`define M_RST_N         0
`define I_OSC           7
`define I_SPLIT         6
`define I_GATE_SYN      5
`define I_GATE_CS       4
`define I_TX_CTRL       3
`define I_RX_CTRL       2
`define I_TX_POL        1
`define I_RX_POL        0
`define PD_RXCHAIN_OFF  2'h1
`define PD_SEQUENCE     2'h3
`define CAL_NEVER       2'h0
`define CAL_ALWAYS      2'h1
`define CAL_EVERY16     2'h2
`define CAL_EVERY256    2'h3
`define TEST_MODE_DEF   3'h1
`define CFG_FRAME_BITS  5'h10
`define CFG_ADDR_BITS   5'h08
`endif

// >>> hw/seq_pin_pkg.sv
// Types shared by the control register block
package seq_pin_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef enum logic [1:0] {PH_IDLE, PH_SHIFT, PH_DONE} cfg_phase_t;
endpackage

// >>> hw/cfg_serial_slave.sv
// Serial configuration port: 7-bit address, write flag, 8 data bits, MSB first
`timescale 1ns/1ps
`default_nettype none
`include "seq_pin_defines.svh"
module cfg_serial_slave (
    input  wire logic               clock,   // Reference clock
    input  wire logic               rst_n,   // Async reset, active low
    input  wire logic               cfg_clk, // Serial bit clock
    input  wire logic               cfg_sel_n, // Frame select, active low
    input  wire logic               cfg_din, // Serial data in
    output logic                    cfg_dout, // Serial data out
    input  wire seq_pin_pkg::reg_byte_t rdata, // Read data of addressed reg
    output logic [6:0]              addr,    // Register address
    output seq_pin_pkg::reg_byte_t  wdata,   // Write data
    output logic                    wr_pulse // One-cycle write strobe
);
    seq_pin_pkg::cfg_phase_t ph_q;
    logic [4:0]  cnt_q;
    logic [15:0] sh_q;
    logic [7:0]  rd_q;
    logic        clk_d1_q;
    logic        dout_q;
    wire rise = cfg_clk & ~clk_d1_q;
    wire fall = ~cfg_clk & clk_d1_q;
    wire last = (cnt_q == `CFG_FRAME_BITS - 5'h1);
    // Reads load at the flag bit so the first data bit leaves on the next fall
    wire load_rd = rise & (cnt_q == `CFG_ADDR_BITS - 5'h1) & ~cfg_din;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ph_q     <= seq_pin_pkg::PH_IDLE;
            cnt_q    <= 5'h00;
            sh_q     <= 16'h0000;
            clk_d1_q <= 1'b0;
            wr_pulse <= 1'b0;
        end else begin
            clk_d1_q <= cfg_clk;
            wr_pulse <= 1'b0;
            unique case (ph_q)
                seq_pin_pkg::PH_IDLE: begin
                    cnt_q <= 5'h00;
                    if (!cfg_sel_n) ph_q <= seq_pin_pkg::PH_SHIFT;
                end
                seq_pin_pkg::PH_SHIFT: begin
                    if (cfg_sel_n) ph_q <= seq_pin_pkg::PH_IDLE;
                    else if (rise) begin
                        sh_q  <= {sh_q[14:0], cfg_din};
                        cnt_q <= cnt_q + 5'h01;
                        if (last) begin
                            ph_q     <= seq_pin_pkg::PH_DONE;
                            wr_pulse <= sh_q[7];
                        end
                    end
                end
                seq_pin_pkg::PH_DONE: begin
                    if (cfg_sel_n) ph_q <= seq_pin_pkg::PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_q   <= 8'h00;
            dout_q <= 1'b0;
        end else if (load_rd) begin
            rd_q <= rdata;
        end else if (fall && ph_q == seq_pin_pkg::PH_SHIFT) begin
            dout_q <= rd_q[7];
            rd_q   <= {rd_q[6:0], 1'b0};
        end
    end

    // A read fetches its word at the flag bit, when only seven address bits are in
    assign addr     = (cnt_q == `CFG_FRAME_BITS) ? sh_q[15:9] : sh_q[6:0];
    assign wdata    = sh_q[7:0];
    assign cfg_dout = dout_q;
endmodule
`default_nettype wire

// >>> hw/seq_pin_ctrl.sv
// Main control and pin interface registers with sequencing triggers
//
// Overview of operation
// - Sequencing is enabled only when power-down policy equals 3.
// - Main bit 6 selects frequency set A when 0, B when 1.
// - Calibration policy: never, every, every 16th, every 256th sequence end.
// - Rising write of sleep trigger powers down and awaits a new sequence.
// - Writing soft reset low loads defaults into all but main register.
// - Main register loads its default only at power-on reset; soft reset leaves it alone.
// - Oscillator select 1 powers internal oscillator down for external clock.
// - Split bit 0: data pin outputs in receive, inputs in transmit.
// - Split bit 1: data pin input; receive data on lock or bit clock.
// - Split, no chip-select trigger, policy 3: data pin fall starts sequence.
// - Synth gating with policy 01 holds bit clock high unless locked.
// - Carrier gating holds bit clock high unless carrier sensed.
// - Transmit amp pin follows internal amp when enabled, else polarity bit.
// - Receive amp pin follows internal amp when enabled, else polarity bit.
// - Polarity bits set amp pin active level: 0 low, 1 high.
// - Test enables route low interface bits to test controls, else defaults.
// - Chip-select trigger set: chip-select falling edge starts a sequence.
// - Main bit 7 selects receive when 0, transmit when 1.
`timescale 1ns/1ps
`default_nettype none
`include "seq_pin_defines.svh"
module seq_pin_ctrl #(
    parameter int SEQ_CNT_W = 8 // Width of completed-sequence counter
) (
    input  wire logic        clock,               // 40 MHz reference clock
    input  wire logic        rst_n,               // Async reset, active low
    input  wire logic        cfg_clk,             // Config bus bit clock
    input  wire logic        cfg_sel_n,           // Config chip select
    input  wire logic        cfg_din,             // Config serial in
    output logic             cfg_dout,            // Config serial out
    input  wire logic        bidir_data_pin_rx,   // Data pin level
    output logic             bidir_data_pin_drv,  // Data pin drive value
    output logic             bidir_data_pin_oe_n, // Data pin enable, low drives
    output logic             lock_pin,            // Lock or receive data pin
    output logic             bit_clock_pin,       // Bit clock pin
    output logic             tx_amp_enable_pin,   // External PA enable pin
    output logic             rx_amp_enable_pin,   // External LNA enable pin
    input  wire logic        rx_data,             // Demodulated receive data
    input  wire logic        sync_mode,           // 1: synchronous data mode
    input  wire logic        bit_clock_raw,       // Ungated bit clock
    input  wire logic        synth_locked,        // Synthesizer lock
    input  wire logic        carrier_sense,       // Carrier sense indication
    input  wire logic        pa_on,               // Internal PA powered
    input  wire logic        lna_on,              // Internal LNA powered
    input  wire logic        seq_chipsel_trigger, // Chip select starts sequence
    input  wire logic        test_path_a_on,      // Test enable A
    input  wire logic        test_path_b_on,      // Test enable B
    input  wire logic        seq_done,            // Sequence finished pulse
    output logic             tx_data,             // Transmit data to modulator
    output logic             dir_select,          // 0 receive, 1 transmit
    output logic             freq_bank_b,         // 1: frequency set B
    output logic [1:0]       powerdown_policy,    // Power-down mode field
    output logic             seq_enable,          // Auto sequencing on
    output logic             seq_start,           // Start sequence pulse
    output logic             seq_asleep,          // Waiting for a trigger
    output logic             cal_request,         // Calibrate synth pulse
    output logic             osc_external_select, // Internal oscillator off
    output logic             regs_in_reset,       // Soft reset held
    output logic             analog_test_sleep,   // Analog test power-down
    output logic [2:0]       test_mode            // Analog test mode
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (SEQ_CNT_W < 8) begin : g_chk
        $error("SEQ_CNT_W must be at least 8");
    end

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    logic [6:0]             addr;
    seq_pin_pkg::reg_byte_t wdata;
    logic                   wr_pulse;
    seq_pin_pkg::reg_byte_t main_q;
    seq_pin_pkg::reg_byte_t iface_q;
    seq_pin_pkg::reg_byte_t iface_d;

    wire hit_main  = (addr == `ADDR_MAIN);
    wire hit_iface = (addr == `ADDR_IFACE);
    wire wr_main   = wr_pulse & hit_main;
    wire wr_iface  = wr_pulse & hit_iface;
    wire seq_pin_pkg::reg_byte_t rdata = hit_main  ? main_q :
                                        hit_iface ? iface_q : 8'h00;

    cfg_serial_slave u_cfg (
        .clock    (clock),
        .rst_n    (rst_n),
        .cfg_clk  (cfg_clk),
        .cfg_sel_n(cfg_sel_n),
        .cfg_din  (cfg_din),
        .cfg_dout (cfg_dout),
        .rdata    (rdata),
        .addr     (addr),
        .wdata    (wdata),
        .wr_pulse (wr_pulse)
    );

    // Only the power-on reset touches main; soft reset never does
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) main_q <= `MAIN_POR;
        else if (wr_main) main_q <= wdata;
    end

    // Interface stays at defaults until the host releases soft reset
    wire soft_rst = ~main_q[`M_RST_N];
    assign iface_d = soft_rst ? `IFACE_DEF :
                     wr_iface ? wdata : iface_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) iface_q <= `IFACE_DEF;
        else iface_q <= iface_d;
    end

    // ------------------------------------------------------------
    // Main register decode
    // ------------------------------------------------------------
    wire [1:0] pd_pol  = main_q[`M_PD_HI:`M_PD_LO];
    wire [1:0] cal_pol = main_q[`M_CAL_HI:`M_CAL_LO];
    assign dir_select       = main_q[`M_DIR];
    assign freq_bank_b      = main_q[`M_BANK];
    assign powerdown_policy = pd_pol;
    assign seq_enable       = (pd_pol == `PD_SEQUENCE);
    assign regs_in_reset    = soft_rst;

    // ------------------------------------------------------------
    // Sequencing triggers
    // ------------------------------------------------------------
    logic sel_d1_q;
    logic dio_d1_q;
    logic asleep_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_d1_q <= 1'b1;
            dio_d1_q <= 1'b1;
        end else begin
            sel_d1_q <= cfg_sel_n;
            dio_d1_q <= bidir_data_pin_rx;
        end
    end
    wire split    = iface_q[`I_SPLIT];
    wire sel_fall = sel_d1_q & ~cfg_sel_n;
    wire dio_fall = dio_d1_q & ~bidir_data_pin_rx;
    wire by_sel   = seq_chipsel_trigger & sel_fall;
    wire by_dio   = ~seq_chipsel_trigger & split & dio_fall;
    // Triggers count only while asleep, so config traffic mid-sequence is harmless
    wire start_ev = seq_enable & asleep_q & (by_sel | by_dio);
    // Rising edge of the written sleep bit against the stored one
    wire sleep_ev = wr_main & seq_enable &
                    wdata[`M_SLEEP] & ~main_q[`M_SLEEP];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) asleep_q <= 1'b0;
        else if (!seq_enable) asleep_q <= 1'b0;
        else if (sleep_ev) asleep_q <= 1'b1;
        else if (start_ev) asleep_q <= 1'b0;
    end
    assign seq_asleep = asleep_q;
    assign seq_start  = start_ev;

    // ------------------------------------------------------------
    // Calibration pacing
    // ------------------------------------------------------------
    logic [SEQ_CNT_W-1:0] seq_cnt_q;
    logic                 cal_q;
    wire done_ev = seq_done & seq_enable;
    wire hit16   = (seq_cnt_q[3:0] == 4'hF);
    wire hit256  = (seq_cnt_q[7:0] == 8'hFF);
    wire cal_d   = done_ev & ((cal_pol == `CAL_ALWAYS) |
                              (cal_pol == `CAL_EVERY16 & hit16) |
                              (cal_pol == `CAL_EVERY256 & hit256));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seq_cnt_q <= '0;
            cal_q     <= 1'b0;
        end else begin
            cal_q <= cal_d;
            if (soft_rst) seq_cnt_q <= '0;
            else if (done_ev) seq_cnt_q <= seq_cnt_q + 1'b1;
        end
    end
    assign cal_request = cal_q;

    // ------------------------------------------------------------
    // Pin interface
    // ------------------------------------------------------------
    wire test_on = test_path_a_on | test_path_b_on;
    wire tx_pol  = iface_q[`I_TX_POL];
    wire rx_pol  = iface_q[`I_RX_POL];
    // Active level follows polarity; idle level is its inverse
    wire tx_amp_d = iface_q[`I_TX_CTRL] ? (pa_on ? tx_pol : ~tx_pol)
                                        : tx_pol;
    wire rx_amp_d = iface_q[`I_RX_CTRL] ? (lna_on ? rx_pol : ~rx_pol)
                                        : rx_pol;
    wire gate_syn = iface_q[`I_GATE_SYN] &
                    (pd_pol == `PD_RXCHAIN_OFF) & ~synth_locked;
    wire gate_cs  = iface_q[`I_GATE_CS] & ~carrier_sense;
    wire clk_sync = bit_clock_raw | gate_syn | gate_cs;
    // Split asynchronous mode gives the clock pin over to receive data
    wire clk_d    = (split & ~sync_mode) ? rx_data : clk_sync;
    wire lock_d   = (split & sync_mode) ? rx_data : synth_locked;
    wire drive_d  = ~split & ~dir_select;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_amp_enable_pin   <= 1'b0;
            rx_amp_enable_pin   <= 1'b0;
            bit_clock_pin       <= 1'b1;
            lock_pin            <= 1'b0;
            bidir_data_pin_drv  <= 1'b0;
            bidir_data_pin_oe_n <= 1'b1;
            tx_data             <= 1'b0;
        end else begin
            tx_amp_enable_pin   <= tx_amp_d;
            rx_amp_enable_pin   <= rx_amp_d;
            bit_clock_pin       <= clk_d;
            lock_pin            <= lock_d;
            bidir_data_pin_drv  <= rx_data;
            bidir_data_pin_oe_n <= ~drive_d;
            tx_data             <= bidir_data_pin_rx;
        end
    end

    assign osc_external_select = iface_q[`I_OSC];
    assign analog_test_sleep   = test_on ? iface_q[3] : 1'b1;
    assign test_mode           = test_on ? iface_q[2:0] : `TEST_MODE_DEF;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    bank_select_a: assert property (@(posedge clock) disable iff (!rst_n)
        wr_main |=> freq_bank_b == $past(wdata[`M_BANK]))
        else $error("bank select does not follow write");

    dir_select_a: assert property (@(posedge clock) disable iff (!rst_n)
        wr_main |=> dir_select == $past(wdata[`M_DIR]))
        else $error("direction does not follow write");

    seq_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
        seq_enable == (powerdown_policy == 2'h3))
        else $error("sequencing enable wrong");

    main_kept_a: assert property (@(posedge clock) disable iff (!rst_n)
        !wr_main |=> main_q == $past(main_q))
        else $error("main register changed without write");

    soft_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
        soft_rst |=> iface_q == `IFACE_DEF)
        else $error("interface not at default under soft reset");

    sleep_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_main && seq_enable && wdata[1] && !main_q[1])
        |=> seq_asleep)
        else $error("rising sleep bit did not power down");

    sleep_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (seq_asleep && !seq_start && seq_enable && !wr_main)
        |=> seq_asleep)
        else $error("left sleep without trigger");

    cal_every_a: assert property (@(posedge clock) disable iff (!rst_n)
        (seq_done && seq_enable && cal_pol == 2'h1) |=> cal_request)
        else $error("calibration missing for every-sequence policy");

    cal_never_a: assert property (@(posedge clock) disable iff (!rst_n)
        (cal_pol == 2'h0 && $past(cal_pol) == 2'h0) |-> !cal_request)
        else $error("calibration with never policy");

    cal_pace_a: assert property (@(posedge clock) disable iff (!rst_n)
        (seq_done && seq_enable && cal_pol == 2'h2 && seq_cnt_q[3:0] != 4'hF)
        |=> !cal_request)
        else $error("16th policy calibrated off schedule");

    sel_start_a: assert property (@(posedge clock) disable iff (!rst_n)
        (seq_enable && seq_asleep && seq_chipsel_trigger &&
         $fell(cfg_sel_n)) |-> seq_start ##1 !seq_asleep)
        else $error("chip select fall did not start sequence");

    dio_start_a: assert property (@(posedge clock) disable iff (!rst_n)
        (seq_enable && seq_asleep && !seq_chipsel_trigger && split &&
         $fell(bidir_data_pin_rx)) |-> seq_start)
        else $error("data pin fall did not start sequence");

    osc_select_a: assert property (@(posedge clock) disable iff (!rst_n)
        osc_external_select == iface_q[7])
        else $error("oscillator select wrong");

    dio_dir_a: assert property (@(posedge clock) disable iff (!rst_n)
        split |=> bidir_data_pin_oe_n)
        else $error("data pin driven while split");

    dio_rx_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!split && !dir_select) |=> !bidir_data_pin_oe_n)
        else $error("data pin not driven in receive");

    syn_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        (iface_q[5] && powerdown_policy == 2'h1 && !synth_locked &&
         !(split && !sync_mode)) |=> bit_clock_pin)
        else $error("bit clock not held high without lock");

    cs_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        (iface_q[4] && !carrier_sense && !(split && !sync_mode))
        |=> bit_clock_pin)
        else $error("bit clock not held high without carrier");

    tx_amp_a: assert property (@(posedge clock) disable iff (!rst_n)
        !iface_q[3] |=> tx_amp_enable_pin == $past(iface_q[1]))
        else $error("tx amp pin not at polarity bit");

    rx_amp_a: assert property (@(posedge clock) disable iff (!rst_n)
        (iface_q[2] && lna_on) |=> rx_amp_enable_pin == $past(iface_q[0]))
        else $error("rx amp pin not at active level");

    test_route_a: assert property (@(posedge clock) disable iff (!rst_n)
        !(test_path_a_on || test_path_b_on) |-> analog_test_sleep &&
        test_mode == 3'h1)
        else $error("test defaults wrong");
endmodule
`default_nettype wire

// >>> dv/cfg_host_model.sv
// Host model: serial configuration master of the control registers
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
    input  wire logic clock,     // Reference clock
    output logic      cfg_clk,   // Serial bit clock
    output logic      cfg_sel_n, // Frame select, active low
    output logic      cfg_din,   // Serial data to device
    input  wire logic cfg_dout   // Serial data from device
);
    initial begin
        cfg_clk = 1'b0;
        cfg_sel_n = 1'b1;
        cfg_din = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Three cycles a phase leaves margin over the one-cycle minimum
    task automatic put(input logic b);
        cfg_din = b;
        cfg_clk = 1'b1;
        hold(3);
        cfg_clk = 1'b0;
        hold(3);
    endtask
    task automatic frame(input logic [6:0] a, input logic w);
        cfg_sel_n = 1'b0;
        hold(1);
        for (int i = 6; i >= 0; i--) put(a[i]);
        put(w);
    endtask
    task automatic done();
        cfg_sel_n = 1'b1;
        cfg_din = ~cfg_din; // Released line must not show a stale bit
        hold(3);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        frame(a, 1'b1);
        for (int i = 7; i >= 0; i--) put(d[i]);
        done();
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        frame(a, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            d[i] = cfg_dout;
            if (i > 0) put(1'b0);
        end
        done();
    endtask
endmodule
`default_nettype wire

// >>> dv/test_seq_and_pin_interface_ctrl.sv
// Testbench of the main control and pin interface registers
`timescale 1ns/1ps
`default_nettype none
module test_seq_and_pin_interface_ctrl;
    logic clock, rst_n, dpin, rx_data, sync_mode, bit_clock_raw, synth_locked;
    logic carrier_sense, pa_on, lna_on, trig_cs, tp_a, tp_b, seq_done;
    wire  cfg_clk, cfg_sel_n, cfg_din, cfg_dout, drv, oe_n, bclk, txa, rxa, osc;
    wire  dir, bank, seq_en, sst, asleep, cal, tsl, lck, txd, rir;
    wire  [1:0] pd;
    wire  [2:0] tm;
    wire  line_lvl = oe_n ? dpin : drv;
    int   errors, checks_done, n_start, n_cal, cyc, base;
    logic [7:0] d;
    localparam logic [11:0] ROWS [6] = '{12'h000, 12'h033, 12'h0C9, 12'h0F5, 12'h8EE, 12'h0C6};
    localparam int CALS [4] = '{0, 256, 16, 1};
    cfg_host_model cfg_host_model_i (.clock, .cfg_clk, .cfg_sel_n, .cfg_din, .cfg_dout);
    seq_pin_ctrl seq_pin_ctrl_i (.clock, .rst_n, .cfg_clk, .cfg_sel_n, .cfg_din, .cfg_dout,
        .bidir_data_pin_rx(line_lvl), .bidir_data_pin_drv(drv), .bidir_data_pin_oe_n(oe_n),
        .lock_pin(lck), .bit_clock_pin(bclk), .tx_amp_enable_pin(txa), .rx_amp_enable_pin(rxa),
        .rx_data, .sync_mode, .bit_clock_raw, .synth_locked, .carrier_sense, .pa_on, .lna_on,
        .seq_chipsel_trigger(trig_cs), .test_path_a_on(tp_a), .test_path_b_on(tp_b),
        .seq_done, .tx_data(txd), .dir_select(dir), .freq_bank_b(bank), .powerdown_policy(pd),
        .seq_enable(seq_en), .seq_start(sst), .seq_asleep(asleep), .cal_request(cal),
        .osc_external_select(osc), .regs_in_reset(rir), .analog_test_sleep(tsl), .test_mode(tm));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic tick(input int n);
        cfg_host_model_i.hold(n);
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Cycle watchdog also counts the one-cycle pulses
    always @(posedge clock) begin
        cyc++;
        if (sst === 1'b1) n_start++;
        if (cal === 1'b1) n_cal++;
        if (cyc > 60000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, rx_data, sync_mode, bit_clock_raw, synth_locked, carrier_sense} = '0;
        {pa_on, lna_on, trig_cs, tp_a, tp_b, seq_done} = '0;
        dpin = 1'b1;
        tick(4);
        rst_n = 1'b1;
        chk({bclk, oe_n, rir}, 3'b111);
        cfg_host_model_i.wr(7'h01, 8'h80);
        chk(osc, 1'b0);
        cfg_host_model_i.wr(7'h00, 8'h01);
        foreach (ROWS[i]) begin
            cfg_host_model_i.wr(7'h01, ROWS[i][11:4]);
            {pa_on, lna_on} = ROWS[i][3:2];
            tick(2);
            chk({txa, rxa}, ROWS[i][1:0]);
            chk(osc, ROWS[i][11]);
            chk({oe_n, tsl, tm}, 5'h09);
        end
        $display("done: pin rows");
        tp_a = 1'b1;
        cfg_host_model_i.wr(7'h01, 8'h13);
        chk({tsl, tm}, 4'h3);
        {tp_a, tp_b, sync_mode} = 3'b011;
        tick(2);
        chk({tsl, tm, bclk}, 5'h07);
        carrier_sense = 1'b1;
        tick(2);
        chk(bclk, 1'b0);
        {tp_b, sync_mode} = 2'b00;
        cfg_host_model_i.wr(7'h00, 8'h11);
        cfg_host_model_i.wr(7'h01, 8'h20);
        chk(bclk, 1'b1);
        synth_locked = 1'b1;
        tick(2);
        chk(bclk, 1'b0);
        synth_locked = 1'b0;
        $display("done: test and gating");
        trig_cs = 1'b1;
        cfg_host_model_i.wr(7'h00, 8'h31);
        cfg_host_model_i.wr(7'h00, 8'h33);
        chk({seq_en, pd, asleep}, 4'hF);
        base = n_start;
        cfg_host_model_i.rd(7'h05, d);
        chk(d, 8'h00);
        chk({8'(n_start - base), asleep}, 9'h002);
        cfg_host_model_i.wr(7'h00, 8'h73);
        chk({bank, asleep, 8'(n_start - base)}, 10'h201);
        trig_cs = 1'b0;
        cfg_host_model_i.wr(7'h01, 8'h40);
        cfg_host_model_i.wr(7'h00, 8'h71);
        cfg_host_model_i.wr(7'h00, 8'h73);
        chk({oe_n, asleep, 8'(n_start - base)}, 10'h301);
        dpin = 1'b0;
        tick(3);
        chk(n_start - base, 2);
        dpin = 1'b1;
        {sync_mode, rx_data} = 2'b11;
        tick(2);
        chk({lck, bclk, txd}, 3'b101);
        sync_mode = 1'b0;
        tick(2);
        chk({lck, bclk, txd}, 3'b011);
        rx_data = 1'b0;
        $display("done: sequencing");
        for (int c = 0; c < 4; c++) begin
            cfg_host_model_i.wr(7'h00, {4'h7, c[1:0], 2'b00});
            cfg_host_model_i.wr(7'h00, {4'h7, c[1:0], 2'b01});
            base = n_cal;
            repeat (256) begin
                seq_done = 1'b1;
                tick(1);
                seq_done = 1'b0;
                tick(1);
            end
            tick(2);
            chk(n_cal - base, CALS[c]);
        end
        chk({bank, pd, oe_n}, 4'hE);
        cfg_host_model_i.wr(7'h00, 8'h81);
        cfg_host_model_i.rd(7'h00, d);
        chk({d, dir, oe_n}, 10'h207);
        $display("done: calibration and mode");
        wrap_up();
    end
endmodule
`default_nettype wire
